/* host_port_model.sv */
// Purpose: Host side of the register port.
// Assumes: Requests change on the falling edge, one access at a time.
// Notes:   Address and data are inverted once released, so stale values never look valid.
`default_nettype none

module host_port_model
  import uart_irq_pkg::*;
(
  // Clock and read data
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  // Request toward the block
  output var reg_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_req = '0;

  task automatic access(input logic [3:0] addr, input logic wr, input logic [7:0] data,
                        output logic [7:0] rdata);
    @(negedge i_clk);
    o_req = '{addr: addr, wr: wr, rd: !wr, wdata: data};
    @(negedge i_clk);
    rdata = i_rdata;
    o_req = '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~data};
  endtask : access
endmodule : host_port_model

`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench for the UART interrupt and line-status block.
// Assumes: Receive FIFO modelled here as a queue of error codes.
// Notes:   Transmit spaces stay at 64 whenever the holding register is shown empty.
`default_nettype none

module testbench
  import uart_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic I_REF_CLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic [7:0] line_control_register = 8'h00;
  logic fifo_en = 1'b1;
  logic [LEVEL_W-1:0] rx_trig = 7'h04;
  logic [LEVEL_W-1:0] tx_trig = 7'h08;
  rx_stat_s rx = '0;
  tx_stat_s tx = '0;
  logic [3:0] delta = 4'h0;
  reg_req_s req;
  logic [7:0] rdata;
  cfg_s cfg;
  logic enh_en;
  logic irq;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'h4f55;
  logic [2:0] errq[$];
  logic ovr = 1'b0;
  logic [7:0] mask = 8'h00;
  logic [7:0] got;
  logic [31:0] r;

  always #5 I_REF_CLK = ~I_REF_CLK;

  host_port_model host (.i_clk(I_REF_CLK), .i_rdata(rdata), .o_req(req));

  uart_irq_ctrl DUT (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN), .I_REG(req), .I_LCR(line_control_register), .O_RDATA(rdata),
    .I_FIFO_EN(fifo_en), .I_RX_TRIG(rx_trig), .I_TX_TRIG(tx_trig), .I_RX(rx), .I_TX(tx),
    .I_MODEM_DELTA(delta), .I_MODEM_LINES(4'ha), .O_CFG(cfg), .O_ENH_EN(enh_en), .O_IRQ(irq));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] lsr_exp();
    logic [7:0] v;
    v = {1'b0, tx.hold_empty & tx.shift_empty, tx.hold_empty, 3'h0, ovr, errq.size() != 0};
    foreach (errq[i]) v[7] |= (errq[i] != 3'h0);
    if (errq.size() != 0) v[4:2] = errq[0];
    return v;
  endfunction : lsr_exp

  // Valid only while transmit and modem sources are idle
  function automatic logic [7:0] stat_exp();
    logic line;
    logic rxp;
    line = mask[2] && (lsr_exp() & 8'h9e) != 8'h00;
    rxp = mask[0] && (fifo_en ? errq.size() >= rx_trig : errq.size() != 0);
    return {{2{fifo_en}}, line ? SRC_LINE : rxp ? SRC_RECEIVE_READY_EVENT : SRC_NONE};
  endfunction : stat_exp

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host.access(a, 1'b1, d, got);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    host.access(a, 1'b0, 8'h00, got);
    chk(got, e);
  endtask : rdchk

  // Cause lands one edge in, the pin one edge later
  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    repeat (2) @(negedge I_REF_CLK);
    while (irq !== v && n < 4) begin
      @(negedge I_REF_CLK);
      n++;
    end
    chk({7'h0, irq}, {7'h0, v});
  endtask : wait_irq

  task automatic rx_op(input logic push, input logic [2:0] e, input logic o);
    @(negedge I_REF_CLK);
    rx.push = push;
    rx.pop = !push;
    rx.push_err = push && e != 3'h0;
    rx.pop_err = !push && errq[0] != 3'h0;
    rx.overrun = o;
    @(negedge I_REF_CLK);
    if (push) errq.push_back(e);
    else void'(errq.pop_front());
    ovr |= o;
    rx = '{push: 1'b0, push_err: 1'b0, pop: 1'b0, pop_err: 1'b0, overrun: 1'b0, clear: 1'b0,
           head_err: (errq.size() != 0) ? errq[0] : 3'h0, level: LEVEL_W'(errq.size())};
  endtask : rx_op

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    repeat (10) @(negedge I_REF_CLK);
    I_RSTN = 1'b1;
    rdchk(ADDR_MASK, 8'h00);
    rdchk(ADDR_STAT, 8'hc1);
    // ----------------------------------------
    // Banked registers
    // ----------------------------------------
    wr(ADDR_GPIO_STATE, 8'h96);
    rdchk(ADDR_GPIO_STATE, 8'h96);
    wr(ADDR_GPIO_IEN, 8'h69);
    rdchk(ADDR_GPIO_IEN, 8'h69);
    wr(ADDR_RSVD, 8'hff);
    rdchk(ADDR_RSVD, 8'h00);
    wr(ADDR_MASK, 8'hf5);
    rdchk(ADDR_MASK, 8'h05);
    line_control_register = 8'h80;
    wr(ADDR_DATA, 8'h5a);
    rdchk(ADDR_DATA, 8'h5a);
    wr(ADDR_MASK, 8'ha5);
    rdchk(ADDR_MASK, 8'ha5);
    wr(ADDR_STAT, 8'h3c);
    rdchk(ADDR_STAT, 8'h00);
    line_control_register = LCR_ENH_SPACE;
    wr(ADDR_STAT, 8'h10);
    rdchk(ADDR_STAT, 8'h10);
    for (int a = 4; a < 8; a++) begin
      wr(a[3:0], 8'(8'h30 + a));
      rdchk(a[3:0], 8'(8'h30 + a));
    end
    line_control_register = 8'h80;
    wr(ADDR_STAT, 8'h3c);
    rdchk(ADDR_STAT, 8'h3c);
    line_control_register = 8'h00;
    wr(ADDR_MASK, 8'hf0);
    rdchk(ADDR_MASK, 8'hf0);
    wr(ADDR_MASK, 8'h00);
    line_control_register = LCR_ENH_SPACE;
    wr(ADDR_STAT, 8'h00);
    line_control_register = 8'h00;
    // ----------------------------------------
    // Random receive traffic against the model
    // ----------------------------------------
    for (int n = 0; n < 80; n++) begin
      r = rnd();
      if (r[22:20] == 3'h0) begin
        fifo_en = r[23];
        rx_trig = LEVEL_W'(r[25:24]) + 7'h1;
      end
      if (r[15:13] == 3'h0) begin
        mask = {4'h0, r[19:16]};
        wr(ADDR_MASK, mask);
      end
      rx_op(errq.size() == 0 || (r[0] && errq.size() < 64), (r[9:8] == 2'h0) ? r[4:2] : 3'h0, r[12:10] == 3'h0);
      wait_irq(stat_exp() != {{2{fifo_en}}, SRC_NONE});
      rdchk(ADDR_STAT, stat_exp());
      rdchk(ADDR_LINE, lsr_exp());
      ovr = 1'b0;
    end
    // Receive FIFO reset drops the stored characters and their error count
    @(negedge I_REF_CLK);
    rx.clear = 1'b1;
    @(negedge I_REF_CLK);
    errq.delete();
    rx = '0;
    rdchk(ADDR_LINE, lsr_exp());
    // ----------------------------------------
    // Transmit ready and modem status
    // ----------------------------------------
    mask = 8'h00;
    wr(ADDR_MASK, mask);
    fifo_en = 1'b0;
    tx.hold_empty = 1'b1;
    tx.spaces = 7'h40;
    rdchk(ADDR_LINE, 8'h20);
    tx.shift_empty = 1'b1;
    wr(ADDR_MASK, 8'h02);
    wait_irq(1'b1);
    rdchk(ADDR_STAT, {{2{fifo_en}}, SRC_TRANSMIT_READY_EVENT});
    wait_irq(1'b0);
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_MASK, 8'h02);
    wait_irq(1'b1);
    wr(ADDR_DATA, 8'h41);
    wait_irq(1'b0);
    // FIFO mode: ready only once spaces exceed the trigger
    fifo_en = 1'b1;
    tx = '{hold_empty: 1'b0, shift_empty: 1'b0, spaces: tx_trig};
    wait_irq(1'b0);
    rdchk(ADDR_LINE, lsr_exp());
    tx.spaces = tx_trig + 7'h1;
    wait_irq(1'b1);
    rdchk(ADDR_STAT, {{2{fifo_en}}, SRC_TRANSMIT_READY_EVENT});
    wait_irq(1'b0);
    wr(ADDR_MASK, 8'h08);
    @(negedge I_REF_CLK);
    delta = 4'h5;
    @(negedge I_REF_CLK);
    delta = 4'h0;
    wait_irq(1'b1);
    rdchk(ADDR_STAT, {{2{fifo_en}}, SRC_MODEM});
    rdchk(ADDR_MODEM, 8'ha5);
    wait_irq(1'b0);
    finish_test();
  end
endmodule : testbench

`default_nettype wire

/* uart_irq_ctrl.sv */
// Purpose: Interrupt masking, source status, line status and banked registers of the UART.
// Assumes: Register port and datapath status come from logic on I_REF_CLK.
// Notes:   Read data appears one cycle after the read strobe.
`default_nettype none

module uart_irq_ctrl
  import uart_irq_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Register port
  input wire reg_req_s I_REG,
  input wire logic [7:0] I_LCR,
  output logic [7:0] O_RDATA,
  // Datapath status
  input wire logic I_FIFO_EN,
  input wire logic [LEVEL_W-1:0] I_RX_TRIG,
  input wire logic [LEVEL_W-1:0] I_TX_TRIG,
  input wire rx_stat_s I_RX,
  input wire tx_stat_s I_TX,
  input wire logic [3:0] I_MODEM_DELTA,
  input wire logic [3:0] I_MODEM_LINES,
  // Configuration and interrupt
  output cfg_s O_CFG,
  output logic O_ENH_EN,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  cfg_s cfg_reg;
  logic [7:0] rdata_reg;
  logic irq_reg;
  logic data_ready_reg;
  logic overrun_reg;
  logic [LEVEL_W-1:0] err_count_reg;
  logic tx_cond_prev_reg;
  logic tx_pend_reg;
  logic [3:0] delta_reg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic enh_space;
  logic div_space;
  logic std_space;
  logic enh_en;
  logic wr;
  logic rd;

  assign enh_space = (I_LCR == LCR_ENH_SPACE);
  assign div_space = I_LCR[LCR_DIV_BIT] && !enh_space;
  assign std_space = !I_LCR[LCR_DIV_BIT];
  assign enh_en = cfg_reg.enh_ctrl[EFR_ENH_BIT];
  assign wr = I_REG.wr;
  assign rd = I_REG.rd;

  logic stat_read;
  logic modem_read;
  logic line_read;
  logic hold_write;

  assign stat_read = rd && std_space && (I_REG.addr == ADDR_STAT);
  assign modem_read = rd && !enh_space && (I_REG.addr == ADDR_MODEM);
  assign line_read = rd && !enh_space && (I_REG.addr == ADDR_LINE);
  assign hold_write = wr && std_space && (I_REG.addr == ADDR_DATA);

  // ----------------------------------------------------------------
  // Effective mask
  // ----------------------------------------------------------------
  logic [7:0] mask_eff;

  // Upper bits written in enhanced mode stay stored but have no effect without it; a write without it clears them
  assign mask_eff = enh_en ? cfg_reg.irq_mask : (cfg_reg.irq_mask & MASK_STD_BITS);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_reg.div_low <= REG_RESET;
      cfg_reg.div_high <= REG_RESET;
      cfg_reg.frac_div <= REG_RESET;
      cfg_reg.enh_ctrl <= REG_RESET;
      cfg_reg.resume_one <= REG_RESET;
      cfg_reg.resume_two <= REG_RESET;
      cfg_reg.pause_one <= REG_RESET;
      cfg_reg.pause_two <= REG_RESET;
      cfg_reg.gpio_state <= REG_RESET;
      cfg_reg.gpio_ien <= REG_RESET;
      cfg_reg.pin_ctrl <= REG_RESET;
      cfg_reg.extra_ctrl <= REG_RESET;
      cfg_reg.irq_mask <= REG_RESET;
    end else if (wr) begin
      unique case (I_REG.addr)
        ADDR_DATA: begin
          if (div_space) begin
            cfg_reg.div_low <= I_REG.wdata;
          end
        end
        ADDR_MASK: begin
          if (div_space) begin
            cfg_reg.div_high <= I_REG.wdata;
          end else if (std_space) begin
            cfg_reg.irq_mask <= enh_en ? I_REG.wdata : (I_REG.wdata & MASK_STD_BITS);
          end
        end
        ADDR_STAT: begin
          if (enh_space) begin
            cfg_reg.enh_ctrl <= I_REG.wdata;
          end else if (div_space && enh_en) begin
            cfg_reg.frac_div <= I_REG.wdata;
          end
        end
        ADDR_RESUME_CHAR_ONE: begin
          if (enh_space) begin
            cfg_reg.resume_one <= I_REG.wdata;
          end
        end
        ADDR_RESUME_CHAR_TWO: begin
          if (enh_space) begin
            cfg_reg.resume_two <= I_REG.wdata;
          end
        end
        ADDR_PAUSE_CHAR_ONE: begin
          if (enh_space) begin
            cfg_reg.pause_one <= I_REG.wdata;
          end
        end
        ADDR_PAUSE_CHAR_TWO: begin
          if (enh_space) begin
            cfg_reg.pause_two <= I_REG.wdata;
          end
        end
        ADDR_GPIO_STATE: begin
          cfg_reg.gpio_state <= I_REG.wdata;
        end
        ADDR_GPIO_IEN: begin
          cfg_reg.gpio_ien <= I_REG.wdata;
        end
        ADDR_IOCTRL: begin
          cfg_reg.pin_ctrl <= I_REG.wdata;
        end
        ADDR_EXTRA: begin
          cfg_reg.extra_ctrl <= I_REG.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive line status
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] err_count_next;

  // Counting errored entries avoids scanning the FIFO for the global flag
  always_comb begin
    err_count_next = err_count_reg;
    if (I_RX.clear) begin
      err_count_next = '0;
    end else if ((I_RX.push && I_RX.push_err) && !(I_RX.pop && I_RX.pop_err)) begin
      err_count_next = err_count_reg + LEVEL_W'(1);
    end else if (!(I_RX.push && I_RX.push_err) && (I_RX.pop && I_RX.pop_err)) begin
      err_count_next = err_count_reg - LEVEL_W'(1);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      err_count_reg <= '0;
    end else begin
      err_count_reg <= err_count_next;
    end
  end

  // Set wins over the empty clear
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      data_ready_reg <= 1'b0;
    end else if (I_RX.push) begin
      data_ready_reg <= 1'b1;
    end else if (I_RX.level == '0) begin
      data_ready_reg <= 1'b0;
    end
  end

  // Overrun is sticky until the line status is read; a new overrun beats the read
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      overrun_reg <= 1'b0;
    end else if (I_RX.overrun) begin
      overrun_reg <= 1'b1;
    end else if (line_read) begin
      overrun_reg <= 1'b0;
    end
  end

  logic [7:0] line_status;

  always_comb begin
    line_status = 8'h00;
    line_status[0] = data_ready_reg;
    line_status[1] = overrun_reg;
    line_status[4:2] = (I_RX.level != '0) ? I_RX.head_err : 3'h0;
    line_status[5] = I_TX.hold_empty;
    line_status[6] = I_TX.hold_empty && I_TX.shift_empty;
    line_status[7] = (err_count_reg != '0);
  end

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  logic rx_cond;
  logic tx_cond;
  logic line_cond;
  logic modem_cond;

  // Receive ready follows the fill level, so draining below trigger withdraws it
  assign rx_cond = I_FIFO_EN ? (I_RX.level >= I_RX_TRIG) : (I_RX.level != '0);
  assign tx_cond = I_FIFO_EN ? (I_TX.spaces > I_TX_TRIG) : I_TX.hold_empty;
  // Overrun flag counts directly, so it fires before the char reaches the head
  assign line_cond = |{line_status[7], line_status[4:1]};
  assign modem_cond = |delta_reg;

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_cond_prev_reg <= 1'b0;
    end else begin
      tx_cond_prev_reg <= tx_cond;
    end
  end

  logic tx_arm;

  // Enabling the mask bit while already empty arms the source at once
  assign tx_arm = (tx_cond && !tx_cond_prev_reg) ||
                  (tx_cond && wr && std_space && (I_REG.addr == ADDR_MASK) &&
                   I_REG.wdata[MASK_TX_BIT] && !cfg_reg.irq_mask[MASK_TX_BIT]);

  // A new empty event in the clearing cycle is kept
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      tx_pend_reg <= 1'b0;
    end else if (tx_arm) begin
      tx_pend_reg <= 1'b1;
    end else if (stat_read || hold_write || !tx_cond) begin
      tx_pend_reg <= 1'b0;
    end
  end

  // Delta bits: new change beats the read clear
  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      delta_reg <= 4'h0;
    end else if (modem_read) begin
      delta_reg <= I_MODEM_DELTA;
    end else begin
      delta_reg <= delta_reg | I_MODEM_DELTA;
    end
  end

  // ----------------------------------------------------------------
  // Priority and status
  // ----------------------------------------------------------------
  logic line_pend;
  logic rx_pend;
  logic tx_pend;
  logic modem_pend;
  logic [7:0] src_status;

  assign line_pend = mask_eff[MASK_LS_BIT] && line_cond;
  assign rx_pend = mask_eff[MASK_RX_BIT] && rx_cond;
  assign tx_pend = mask_eff[MASK_TX_BIT] && tx_pend_reg;
  assign modem_pend = mask_eff[MASK_MS_BIT] && modem_cond;

  // With all four mask bits clear nothing is pending: polled mode via line status
  always_comb begin
    src_status = {{2{I_FIFO_EN}}, SRC_NONE};
    if (line_pend) begin
      src_status[5:0] = SRC_LINE;
    end else if (rx_pend) begin
      src_status[5:0] = SRC_RECEIVE_READY_EVENT;
    end else if (tx_pend) begin
      src_status[5:0] = SRC_TRANSMIT_READY_EVENT;
    end else if (modem_pend) begin
      src_status[5:0] = SRC_MODEM;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= line_pend || rx_pend || tx_pend || modem_pend;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    unique case (I_REG.addr)
      ADDR_DATA: begin
        rdata_next = div_space ? cfg_reg.div_low : 8'h00;
      end
      ADDR_MASK: begin
        rdata_next = div_space ? cfg_reg.div_high : (std_space ? mask_eff : 8'h00);
      end
      ADDR_STAT: begin
        if (enh_space) begin
          rdata_next = cfg_reg.enh_ctrl;
        end else if (div_space) begin
          rdata_next = enh_en ? cfg_reg.frac_div : 8'h00;
        end else begin
          rdata_next = src_status;
        end
      end
      ADDR_RESUME_CHAR_ONE: begin
        rdata_next = enh_space ? cfg_reg.resume_one : 8'h00;
      end
      ADDR_RESUME_CHAR_TWO: begin
        rdata_next = enh_space ? cfg_reg.resume_two : line_status;
      end
      ADDR_PAUSE_CHAR_ONE: begin
        rdata_next = enh_space ? cfg_reg.pause_one : {I_MODEM_LINES, delta_reg};
      end
      ADDR_PAUSE_CHAR_TWO: begin
        rdata_next = enh_space ? cfg_reg.pause_two : 8'h00;
      end
      ADDR_GPIO_STATE: begin
        rdata_next = cfg_reg.gpio_state;
      end
      ADDR_GPIO_IEN: begin
        rdata_next = cfg_reg.gpio_ien;
      end
      ADDR_IOCTRL: begin
        rdata_next = cfg_reg.pin_ctrl;
      end
      ADDR_EXTRA: begin
        rdata_next = cfg_reg.extra_ctrl;
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_RDATA = rdata_reg;
  assign O_CFG = cfg_reg;
  assign O_ENH_EN = cfg_reg.enh_ctrl[EFR_ENH_BIT];
  assign O_IRQ = irq_reg;

endmodule : uart_irq_ctrl

`default_nettype wire

/* uart_irq_pkg.sv */
// Purpose: Shared constants and carrier types for the UART interrupt and line-status block.
// Assumes: 100 MHz I_REF_CLK, 64-entry receive and transmit FIFOs held outside this block.
// Notes:   Register offsets are the 4-bit internal register addresses.
`default_nettype none

package uart_irq_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_RESUME_CHAR_ONE = 4'h4;
  localparam logic [3:0] ADDR_RESUME_CHAR_TWO = 4'h5;
  localparam logic [3:0] ADDR_PAUSE_CHAR_ONE = 4'h6;
  localparam logic [3:0] ADDR_PAUSE_CHAR_TWO = 4'h7;
  localparam logic [3:0] ADDR_LINE = 4'h5;
  localparam logic [3:0] ADDR_MODEM = 4'h6;
  localparam logic [3:0] ADDR_GPIO_STATE = 4'hb;
  localparam logic [3:0] ADDR_GPIO_IEN = 4'hc;
  localparam logic [3:0] ADDR_RSVD = 4'hd;
  localparam logic [3:0] ADDR_IOCTRL = 4'he;
  localparam logic [3:0] ADDR_EXTRA = 4'hf;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam logic [7:0] LCR_ENH_SPACE = 8'hbf;
  localparam int LCR_DIV_BIT = 7;
  localparam int EFR_ENH_BIT = 4;
  localparam int MASK_RX_BIT = 0;
  localparam int MASK_TX_BIT = 1;
  localparam int MASK_LS_BIT = 2;
  localparam int MASK_MS_BIT = 3;
  localparam logic [7:0] MASK_STD_BITS = 8'h0f;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] SRC_LINE = 6'h06;
  localparam logic [5:0] SRC_RECEIVE_READY_EVENT = 6'h04;
  localparam logic [5:0] SRC_TRANSMIT_READY_EVENT = 6'h02;
  localparam logic [5:0] SRC_MODEM = 6'h00;
  localparam logic [5:0] SRC_NONE = 6'h01;
  localparam int LEVEL_W = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic push;
    logic push_err;
    logic pop;
    logic pop_err;
    logic overrun;
    logic clear;
    logic [2:0] head_err;
    logic [LEVEL_W-1:0] level;
  } rx_stat_s;

  typedef struct packed {
    logic hold_empty;
    logic shift_empty;
    logic [LEVEL_W-1:0] spaces;
  } tx_stat_s;

  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] frac_div;
    logic [7:0] enh_ctrl;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] pause_one;
    logic [7:0] pause_two;
    logic [7:0] gpio_state;
    logic [7:0] gpio_ien;
    logic [7:0] pin_ctrl;
    logic [7:0] extra_ctrl;
    logic [7:0] irq_mask;
  } cfg_s;

endpackage : uart_irq_pkg

`default_nettype wire

/* uart_irq_properties.sv */
// Purpose: Concurrent checks on the ports of the UART interrupt block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Attached by the bind at the foot of this file.
`default_nettype none

module uart_irq_properties
  import uart_irq_pkg::*;
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  // Register port
  input wire reg_req_s I_REG,
  input wire logic [7:0] I_LCR,
  input wire logic [7:0] O_RDATA,
  // Datapath status
  input wire logic I_FIFO_EN,
  input wire logic [LEVEL_W-1:0] I_RX_TRIG,
  input wire logic [LEVEL_W-1:0] I_TX_TRIG,
  input wire rx_stat_s I_RX,
  input wire tx_stat_s I_TX,
  input wire logic [3:0] I_MODEM_DELTA,
  input wire logic [3:0] I_MODEM_LINES,
  // Watched outputs
  input wire cfg_s O_CFG,
  input wire logic O_ENH_EN,
  input wire logic O_IRQ
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RSTN);

  logic rd_line;
  // Line status stays readable in the divisor bank, not in the enhanced one
  assign rd_line = I_REG.rd && I_REG.addr == ADDR_LINE && I_LCR != LCR_ENH_SPACE;

  // Latched causes reach the pin two edges after the pulse
  property late_irq(logic cause, logic en);
    en && cause ##1 en |=> O_IRQ;
  endproperty

  mask_reset_a: assert property ($rose(I_RSTN) |-> O_CFG.irq_mask == REG_RESET)
    else $error("mask not cleared by reset");
  mask_write_a: assert property (I_REG.wr && I_REG.addr == ADDR_MASK && !I_LCR[7] && !O_ENH_EN
    |=> O_CFG.irq_mask == {4'h0, $past(I_REG.wdata[3:0])}) else $error("mask upper bits not held at zero");
  rx_level_a: assert property (O_CFG.irq_mask[0] && I_FIFO_EN && I_RX.level >= I_RX_TRIG |=> O_IRQ)
    else $error("receive trigger did not raise interrupt");
  polled_quiet_a: assert property (O_CFG.irq_mask[3:0] == 4'h0 |=> !O_IRQ)
    else $error("interrupt with all sources masked");
  overrun_irq_a: assert property (late_irq(I_RX.overrun, O_CFG.irq_mask[2]))
    else $error("overrun did not raise interrupt");
  errchar_irq_a: assert property (late_irq(I_RX.push && I_RX.push_err, O_CFG.irq_mask[2]))
    else $error("errored character did not raise interrupt");
  modem_irq_a: assert property (late_irq(|I_MODEM_DELTA, O_CFG.irq_mask[3]))
    else $error("modem delta did not raise interrupt");
  tx_now_a: assert property ($rose(O_CFG.irq_mask[1]) && I_TX.hold_empty |-> ##[1:2] O_IRQ)
    else $error("transmit ready not raised on enable");
  line_bits_a: assert property (rd_line |=> O_RDATA[6:5] ==
    {$past(I_TX.hold_empty && I_TX.shift_empty), $past(I_TX.hold_empty)}) else $error("transmit empty bits wrong");
  head_err_a: assert property (rd_line && I_RX.level != 0 |=> O_RDATA[4:2] == $past(I_RX.head_err))
    else $error("head error bits wrong");

  cover property (O_IRQ && O_CFG.irq_mask[2]);
  cover property (rd_line && I_RX.level != 0);
  cover property ($rose(O_CFG.irq_mask[1]) && I_TX.hold_empty);
endmodule : uart_irq_properties

bind uart_irq_ctrl uart_irq_properties u_props (.I_REF_CLK, .I_RSTN, .I_REG, .I_LCR, .O_RDATA, .I_FIFO_EN,
  .I_RX_TRIG, .I_TX_TRIG, .I_RX, .I_TX, .I_MODEM_DELTA, .I_MODEM_LINES, .O_CFG, .O_ENH_EN, .O_IRQ);

`default_nettype wire
